/* src/dtc_pkg.sv */
`default_nettype none
package dtc_pkg;
  // ==========================================================================
  // bus
  // ==========================================================================
  localparam int unsigned ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CTRL  = 8'h88;
  localparam logic [7:0] IDX_T01_MODE    = 8'h89;
  localparam logic [7:0] IDX_T0_LOW      = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW      = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH     = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH     = 8'h8d;
  localparam logic [7:0] IDX_CLK_DIV     = 8'h8e;
  localparam logic [7:0] IDX_CMP_HIGH    = 8'hc1;
  localparam logic [7:0] IDX_CMP_LOW     = 8'hc2;
  localparam logic [7:0] IDX_T2_CTRL     = 8'hc8;
  localparam logic [7:0] IDX_T2_FLAGS    = 8'hc9;
  localparam logic [7:0] IDX_RELOAD_LOW  = 8'hca;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] IDX_T2_LOW      = 8'hcc;
  localparam logic [7:0] IDX_T2_HIGH     = 8'hcd;
  localparam logic [7:0] IDX_CMP_INV     = 8'hd0;
  localparam logic [7:0] IDX_CMP_PORT    = 8'hd1;
  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0]  RST_CLK_DIV = 8'h01;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned BIT_TF1  = 7;
  localparam int unsigned BIT_TR1  = 6;
  localparam int unsigned BIT_TF0  = 5;
  localparam int unsigned BIT_TR0  = 4;
  localparam int unsigned BIT_T1M  = 4;
  localparam int unsigned BIT_T0M  = 3;
  localparam int unsigned BIT_T2_PRESCALE_SELECT = 7;
  localparam int unsigned BIT_T2R  = 4;
  localparam int unsigned BIT_COMPARE_MODE_SELECT = 2;
  localparam int unsigned BIT_T2I  = 0;
  localparam int unsigned BIT_CCF  = 4;
  localparam int unsigned BIT_TF2  = 0;
  localparam int unsigned BIT_INV  = 0;
  localparam int unsigned BIT_PORT = 0;
  // low field of the 13-bit mode, all ones
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD8,
    DTC_MODE_SPLIT
  } dtc_mode_e;
endpackage
`default_nettype wire

/* src/dtc_timer.sv */
// Contract
// - mode 0 counts 13 bits: high byte over low five bits of low byte.
// - rollover from all ones to zero sets that timer's overflow flag; with timer 0 in mode 3, its high byte sets the timer 1 flag instead.
// - timer 0 counts only while its run bit is one, except its mode 3 high byte.
// - timer 1 counts only while its run bit is one.
// - mode 1 counts the full 16 bits as one cascaded register.
// - mode 2 counts low byte, reloads it from high byte on overflow.
// - mode 3 timer 0 low byte is its own 8-bit counter with own bits.
// - mode 3 timer 0 high byte uses timer 1 run bit and flag.
// - with timer 0 in mode 3, timer 1 keeps counting without its flag.
// - timer 1 in mode 3 holds its count as if stopped.
// - timer 2 is a 16-bit up-counter at full or half clock rate.
// - with reload enabled, timer 2 rollover sets flag and loads reload value.
// - reload happens in the same cycle as the flag, zero never held.
// - timer 2 equal to compare value drives pin action and requests interrupt.
// - compare mode select bit picks between two compare modes.
// - new compare output reaches the pin in the match cycle.
// - compare mode 0 output goes high on match, low on overflow.
// - inversion bit reverses compare output polarity in mode 0.
// - compare mode 1 drives the software port value only at next match.
// - prescale select zero gives full clock, one gives half clock.
// - compare mode select clear gives mode 0, set gives mode 1.
// - timer 2 input select zero stops timer 2.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module dtc_timer
  import dtc_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               compare_output_pin,
  output logic               t0_overflow_flag,
  output logic               t1_overflow_flag,
  output logic               t2_overflow_flag,
  output logic               compare_flag
);
  // ==========================================================================
  // state
  // ==========================================================================
  logic [7:0]  timer_control_register_reg;
  logic [7:0]  t01_mode_reg;
  logic [7:0]  t0_low_byte_reg;
  logic [7:0]  t0_high_byte_reg;
  logic [7:0]  t1_low_byte_reg;
  logic [7:0]  t1_high_byte_reg;
  logic [7:0]  clock_division_register_reg;
  logic [7:0]  t2_control_register_reg;
  logic [7:0]  t2_flag_reg;
  logic [15:0] reload_reg;
  logic [15:0] t2_count_reg;
  logic [15:0] compare_value_reg;
  logic [7:0]  compare_invert_register_reg;
  logic [7:0]  compare_port_reg;
  logic        compare_level_reg;
  logic        compare_output_pin_reg;
  logic        phase_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // timer 0/1 step
  // ==========================================================================
  // returns {overflow, next count}; split mode touches only the low byte
  function automatic logic [16:0] t01_step(input dtc_mode_e m, input logic [15:0] c);
    logic [16:0] r;
    r = {1'b0, c};
    unique case (m)
      DTC_MODE_13BIT: begin
        r[4:0] = c[4:0] + 5'h01;
        if (c[4:0] == PRESCALE_MAX) begin
          r[15:8] = c[15:8] + 8'h01;
          r[16]   = (c[15:8] == 8'hff);
        end
      end
      DTC_MODE_16BIT: r = {1'b0, c} + 17'h00001;
      DTC_MODE_RELOAD8: begin
        r[7:0] = (c[7:0] == 8'hff) ? c[15:8] : c[7:0] + 8'h01;
        r[16]  = (c[7:0] == 8'hff);
      end
      DTC_MODE_SPLIT: begin
        r[7:0] = c[7:0] + 8'h01;
        r[16]  = (c[7:0] == 8'hff);
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // apb decode
  // ==========================================================================
  wire        setup   = psel & ~penable;
  wire [7:0]  acc_idx = paddr[9:2];
  wire        acc_ok  = (paddr[1:0] == 2'b00) && (paddr[AW-1:10] == '0);
  wire        wr_en   = psel & penable & pwrite & pready_reg & acc_ok;
  wire [7:0]  wdata   = pwdata[7:0];
  wire wr_tcr  = wr_en && (acc_idx == IDX_TIMER_CTRL);
  wire wr_mode = wr_en && (acc_idx == IDX_T01_MODE);
  wire wr_t0l  = wr_en && (acc_idx == IDX_T0_LOW);
  wire wr_t0h  = wr_en && (acc_idx == IDX_T0_HIGH);
  wire wr_t1l  = wr_en && (acc_idx == IDX_T1_LOW);
  wire wr_t1h  = wr_en && (acc_idx == IDX_T1_HIGH);
  wire wr_ckd  = wr_en && (acc_idx == IDX_CLK_DIV);
  wire wr_t2c  = wr_en && (acc_idx == IDX_T2_CTRL);
  wire wr_t2f  = wr_en && (acc_idx == IDX_T2_FLAGS);
  wire wr_rll  = wr_en && (acc_idx == IDX_RELOAD_LOW);
  wire wr_rlh  = wr_en && (acc_idx == IDX_RELOAD_HIGH);
  wire wr_t2l  = wr_en && (acc_idx == IDX_T2_LOW);
  wire wr_t2h  = wr_en && (acc_idx == IDX_T2_HIGH);
  wire wr_cml  = wr_en && (acc_idx == IDX_CMP_LOW);
  wire wr_cmh  = wr_en && (acc_idx == IDX_CMP_HIGH);
  wire wr_inv  = wr_en && (acc_idx == IDX_CMP_INV);
  wire wr_port = wr_en && (acc_idx == IDX_CMP_PORT);

  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = acc_ok;
    rd_byte = RST_BYTE;
    case (acc_idx)
      IDX_TIMER_CTRL:  rd_byte = timer_control_register_reg;
      IDX_T01_MODE:    rd_byte = t01_mode_reg;
      IDX_T0_LOW:      rd_byte = t0_low_byte_reg;
      IDX_T0_HIGH:     rd_byte = t0_high_byte_reg;
      IDX_T1_LOW:      rd_byte = t1_low_byte_reg;
      IDX_T1_HIGH:     rd_byte = t1_high_byte_reg;
      IDX_CLK_DIV:     rd_byte = clock_division_register_reg;
      IDX_T2_CTRL:     rd_byte = t2_control_register_reg;
      IDX_T2_FLAGS:    rd_byte = t2_flag_reg;
      IDX_RELOAD_LOW:  rd_byte = reload_reg[7:0];
      IDX_RELOAD_HIGH: rd_byte = reload_reg[15:8];
      IDX_T2_LOW:      rd_byte = t2_count_reg[7:0];
      IDX_T2_HIGH:     rd_byte = t2_count_reg[15:8];
      IDX_CMP_LOW:     rd_byte = compare_value_reg[7:0];
      IDX_CMP_HIGH:    rd_byte = compare_value_reg[15:8];
      IDX_CMP_INV:     rd_byte = compare_invert_register_reg;
      IDX_CMP_PORT:    rd_byte = compare_port_reg;
      default:         rd_hit  = 1'b0;
    endcase
  end

  wire [31:0] prdata_next = (setup & ~pwrite) ? {24'h000000, rd_hit ? rd_byte : RST_BYTE}
                                              : prdata_reg;

  // ==========================================================================
  // clock division
  // ==========================================================================
  wire tick0 = ~clock_division_register_reg[BIT_T0M] | phase_reg;
  wire tick1 = ~clock_division_register_reg[BIT_T1M] | phase_reg;
  wire tick2 = ~t2_control_register_reg[BIT_T2_PRESCALE_SELECT] | phase_reg;

  // ==========================================================================
  // timer 0 and timer 1
  // ==========================================================================
  wire tr0 = timer_control_register_reg[BIT_TR0];
  wire tr1 = timer_control_register_reg[BIT_TR1];
  dtc_mode_e m0;
  dtc_mode_e m1;
  assign m0 = dtc_mode_e'(t01_mode_reg[1:0]);
  assign m1 = dtc_mode_e'(t01_mode_reg[5:4]);
  wire t0_split = (m0 == DTC_MODE_SPLIT);

  wire        t0_run  = tr0 & tick0;
  wire [16:0] t0_step = t01_step(m0, {t0_high_byte_reg, t0_low_byte_reg});
  wire        t0_ovf  = t0_run & t0_step[16];
  wire        th0_run = t0_split & tr1 & tick0;
  wire        th0_ovf = th0_run & (t0_high_byte_reg == 8'hff);

  wire        t1_run  = tr1 & tick1 & (m1 != DTC_MODE_SPLIT);
  wire [16:0] t1_step = t01_step(m1, {t1_high_byte_reg, t1_low_byte_reg});
  wire        t1_ovf  = t1_run & t1_step[16];
  wire        tf1_set = t0_split ? th0_ovf : t1_ovf;

  wire [7:0] t0_low_auto  = t0_run ? t0_step[7:0] : t0_low_byte_reg;
  wire [7:0] t0_high_cnt  = th0_run ? t0_high_byte_reg + 8'h01 : t0_high_byte_reg;
  wire [7:0] t0_high_auto = t0_split ? t0_high_cnt
                          : (t0_run ? t0_step[15:8] : t0_high_byte_reg);
  wire [7:0] t0_low_next  = wr_t0l ? wdata : t0_low_auto;
  wire [7:0] t0_high_next = wr_t0h ? wdata : t0_high_auto;
  wire [7:0] t1_low_next  = wr_t1l ? wdata : (t1_run ? t1_step[7:0] : t1_low_byte_reg);
  wire [7:0] t1_high_next = wr_t1h ? wdata : (t1_run ? t1_step[15:8] : t1_high_byte_reg);

  // flag set wins over a software clear in the same cycle
  wire [7:0] tcr_base = wr_tcr ? wdata : timer_control_register_reg;
  wire [7:0] tcr_next = tcr_base | ({7'h00, tf1_set} << BIT_TF1)
                                 | ({7'h00, t0_ovf} << BIT_TF0);

  // ==========================================================================
  // timer 2
  // ==========================================================================
  wire        t2i      = t2_control_register_reg[BIT_T2I];
  wire        t2r      = t2_control_register_reg[BIT_T2R];
  wire        compare_mode_select     = t2_control_register_reg[BIT_COMPARE_MODE_SELECT];
  wire        t2_run   = t2i & tick2;
  wire        t2_ovf   = t2_run & (t2_count_reg == 16'hffff);
  wire [15:0] t2_wrap  = t2r ? reload_reg : 16'h0000;
  wire [15:0] t2_auto  = !t2_run ? t2_count_reg
                       : (t2_ovf ? t2_wrap : t2_count_reg + 16'h0001);
  wire [15:0] t2_next  = {wr_t2h ? wdata : t2_auto[15:8], wr_t2l ? wdata : t2_auto[7:0]};
  wire [15:0] rl_next  = {wr_rlh ? wdata : reload_reg[15:8], wr_rll ? wdata : reload_reg[7:0]};
  wire [15:0] cmp_next = {wr_cmh ? wdata : compare_value_reg[15:8],
                          wr_cml ? wdata : compare_value_reg[7:0]};

  // match on the count being entered, so pin and flag move with it
  wire cmp_hit = t2_run & (t2_auto == compare_value_reg);
  wire [7:0] t2f_base = wr_t2f ? wdata : t2_flag_reg;
  wire [7:0] t2f_next = t2f_base | ({7'h00, cmp_hit} << BIT_CCF)
                                 | ({7'h00, t2_ovf} << BIT_TF2);

  // ==========================================================================
  // compare output
  // ==========================================================================
  wire inv_bit    = compare_invert_register_reg[BIT_INV];
  wire level_next = cmp_hit ? 1'b1 : (t2_ovf ? 1'b0 : compare_level_reg);
  wire mode1_pin  = cmp_hit ? compare_port_reg[BIT_PORT] : compare_output_pin_reg;
  wire pin_next   = compare_mode_select ? mode1_pin : (level_next ^ inv_bit);

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg  <= RST_RDATA;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      phase_reg   <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= setup;
      pslverr_reg <= setup & ~rd_hit;
      phase_reg   <= ~phase_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_control_register_reg  <= RST_BYTE;
      t01_mode_reg                <= RST_BYTE;
      clock_division_register_reg <= RST_CLK_DIV;
      t0_low_byte_reg             <= RST_BYTE;
      t0_high_byte_reg            <= RST_BYTE;
      t1_low_byte_reg             <= RST_BYTE;
      t1_high_byte_reg            <= RST_BYTE;
    end else begin
      timer_control_register_reg  <= tcr_next;
      t01_mode_reg                <= wr_mode ? wdata : t01_mode_reg;
      clock_division_register_reg <= wr_ckd ? wdata : clock_division_register_reg;
      t0_low_byte_reg             <= t0_low_next;
      t0_high_byte_reg            <= t0_high_next;
      t1_low_byte_reg             <= t1_low_next;
      t1_high_byte_reg            <= t1_high_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t2_control_register_reg     <= RST_BYTE;
      t2_flag_reg                 <= RST_BYTE;
      reload_reg                  <= RST_WORD;
      t2_count_reg                <= RST_WORD;
      compare_value_reg           <= RST_WORD;
      compare_invert_register_reg <= RST_BYTE;
      compare_port_reg            <= RST_BYTE;
      compare_level_reg           <= 1'b0;
      compare_output_pin_reg      <= 1'b0;
    end else begin
      t2_control_register_reg     <= wr_t2c ? wdata : t2_control_register_reg;
      t2_flag_reg                 <= t2f_next;
      reload_reg                  <= rl_next;
      t2_count_reg                <= t2_next;
      compare_value_reg           <= cmp_next;
      compare_invert_register_reg <= wr_inv ? wdata : compare_invert_register_reg;
      compare_port_reg            <= wr_port ? wdata : compare_port_reg;
      compare_level_reg           <= level_next;
      compare_output_pin_reg      <= pin_next;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign compare_output_pin = compare_output_pin_reg;
  assign t0_overflow_flag   = timer_control_register_reg[BIT_TF0];
  assign t1_overflow_flag   = timer_control_register_reg[BIT_TF1];
  assign t2_overflow_flag   = t2_flag_reg[BIT_TF2];
  assign compare_flag       = t2_flag_reg[BIT_CCF];

  // ==========================================================================
  // checks
  // ==========================================================================
  chk_mode13_wrap: assert property (
    (m0 == DTC_MODE_13BIT) && t0_run && !wr_en && (t0_high_byte_reg == 8'hff)
      && (t0_low_byte_reg[4:0] == 5'h1f)
    |=> t0_overflow_flag && (t0_high_byte_reg == 8'h00) && (t0_low_byte_reg[4:0] == 5'h00)
  ) else $error("13-bit wrap did not clear count and set flag");

  chk_mode16_carry: assert property (
    (m0 == DTC_MODE_16BIT) && t0_run && !wr_en && (t0_low_byte_reg == 8'hff)
    |=> t0_high_byte_reg == $past(t0_high_byte_reg) + 8'h01
  ) else $error("16-bit mode did not carry into high byte");

  chk_t0_gate: assert property (
    !tr0 && !wr_en |=> $stable(t0_low_byte_reg)
  ) else $error("timer 0 low byte moved while stopped");

  chk_t1_hold: assert property (
    (!tr1 || (m1 == DTC_MODE_SPLIT)) && !wr_en
    |=> $stable({t1_high_byte_reg, t1_low_byte_reg})
  ) else $error("timer 1 moved while stopped or in mode 3");

  chk_reload8_low: assert property (
    (m0 == DTC_MODE_RELOAD8) && t0_run && !wr_en && (t0_low_byte_reg == 8'hff)
    |=> (t0_low_byte_reg == $past(t0_high_byte_reg)) && $stable(t0_high_byte_reg)
      && t0_overflow_flag
  ) else $error("8-bit reload wrong");

  chk_split_high: assert property (
    t0_split && tr1 && tick0 && !wr_en && (t0_high_byte_reg == 8'hff) |=> t1_overflow_flag
  ) else $error("split high byte overflow did not set timer 1 flag");

  chk_t2_fullrate: assert property (
    t2i && !t2_control_register_reg[BIT_T2_PRESCALE_SELECT] && !wr_en && (t2_count_reg != 16'hffff)
    |=> t2_count_reg == $past(t2_count_reg) + 16'h0001
  ) else $error("timer 2 not counting at full rate");
  // both counting cycles must already run at half rate
  chk_t2_halfrate: assert property (
    t2i && t2_control_register_reg[BIT_T2_PRESCALE_SELECT] && !wr_en
      ##1 t2i && t2_control_register_reg[BIT_T2_PRESCALE_SELECT] && !wr_en
    |=> t2_count_reg != $past(t2_count_reg, 2) + 16'h0002
  ) else $error("timer 2 counted twice in two cycles at half rate");
  chk_t2_reload: assert property (
    t2_ovf && t2r && !wr_en |=> (t2_count_reg == $past(reload_reg)) && t2_overflow_flag
  ) else $error("timer 2 reload missed");
  chk_t2_stop: assert property (
    !t2i && !wr_en |=> $stable(t2_count_reg)
  ) else $error("timer 2 moved with no input");
  chk_cmp_mode0: assert property (
    !compare_mode_select && cmp_hit && !wr_en |=> compare_output_pin == !inv_bit
  ) else $error("mode 0 compare output not set on match");
  chk_cmp_ovf_low: assert property (
    !compare_mode_select && t2_ovf && !cmp_hit && !wr_en |=> compare_output_pin == inv_bit
  ) else $error("mode 0 compare output not cleared on overflow");
  chk_cmp_mode1: assert property (
    compare_mode_select && !wr_en |=> compare_output_pin == ($past(cmp_hit)
      ? $past(compare_port_reg[BIT_PORT]) : $past(compare_output_pin))
  ) else $error("mode 1 pin changed outside a match");
  chk_hit_flag: assert property (
    cmp_hit && !wr_en |=> compare_flag && (t2_count_reg == compare_value_reg)
  ) else $error("compare flag not set with the matching count");
  cov_t2_reload:  cover property (t2_ovf && t2r);
  cov_mode1_hit:  cover property (compare_mode_select && cmp_hit);
  cov_split_high: cover property (th0_ovf);
  cov_mode0_pwm:  cover property (!compare_mode_select && cmp_hit ##[1:300] t2_ovf);
endmodule
`default_nettype wire

/* verification/dtc_timer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_tb;
  import dtc_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, r, s;
  logic [7:0]  th;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin;
  wire  [3:0]  fl;
  int          n_errors, check_count;

  dtc_timer u_dtc_timer (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_output_pin(pin), .t0_overflow_flag(fl[0]),
    .t1_overflow_flag(fl[1]), .t2_overflow_flag(fl[2]), .compare_flag(fl[3]));

  // ==========================================================================
  // bus and compare tasks
  // ==========================================================================
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  // error bit folded into bit 31 of the compared word
  task automatic rd(input logic [7:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00);
    chk({24'h0, x}, {e, r[30:0]});
  endtask
  task automatic wt(input int k, input int lim);
    int i;
    for (i = 0; i < lim && fl[k] !== 1'b1; i++) @(posedge clk);
    chk(32'h1, {31'h0, fl[k]});
  endtask
  task automatic final_report;
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(88));
    th = 8'hf0 | 8'($urandom_range(15));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(IDX_CLK_DIV, RST_CLK_DIV);
    rd(IDX_TIMER_CTRL, RST_BYTE);
    apb(1'b0, 8'h00, 8'h00);
    chk(32'h8000_0000, {e, r[30:0]});
    // timer 0 auto reload at half rate
    wr(IDX_T01_MODE, 8'h02);
    wr(IDX_T0_HIGH, th);
    wr(IDX_T0_LOW, th);
    wr(IDX_CLK_DIV, 8'h08);
    wr(IDX_TIMER_CTRL, 8'h10);
    wt(0, 80);
    rd(IDX_T0_HIGH, th);
    apb(1'b0, IDX_T0_LOW, 8'h00);
    chk(32'h1, {31'h0, r[7:0] >= th});
    wr(IDX_TIMER_CTRL, 8'h00);
    apb(1'b0, IDX_T0_LOW, 8'h00);
    s = r;
    rd(IDX_T0_LOW, s[7:0]);
    // timers 0 and 1 in 13-bit mode roll after two counts, then in 16-bit mode; timer 1 holds in mode 3
    wr(IDX_T01_MODE, 8'h00);
    wr(IDX_T1_HIGH, 8'hff);
    wr(IDX_T1_LOW, 8'h1e);
    wr(IDX_T0_HIGH, 8'hff);
    wr(IDX_T0_LOW, 8'h1e);
    wr(IDX_CLK_DIV, 8'h18);
    wr(IDX_TIMER_CTRL, 8'h50);
    wt(1, 8);
    wt(0, 8);
    rd(IDX_T1_HIGH, 8'h00);
    wr(IDX_T01_MODE, 8'h11);
    wr(IDX_TIMER_CTRL, 8'h00);
    wr(IDX_T1_HIGH, 8'hff);
    wr(IDX_T1_LOW, 8'hf8);
    wr(IDX_T0_HIGH, 8'hff);
    wr(IDX_T0_LOW, 8'hf8);
    wr(IDX_TIMER_CTRL, 8'h50);
    wt(1, 20);
    wt(0, 20);
    rd(IDX_T1_HIGH, 8'h00);
    wr(IDX_T01_MODE, 8'h30);
    apb(1'b0, IDX_T1_LOW, 8'h00);
    s = r;
    rd(IDX_T1_LOW, s[7:0]);
    // split timer 0: high byte on timer 1 run bit and flag
    wr(IDX_TIMER_CTRL, 8'h00);
    wr(IDX_T01_MODE, 8'h33);
    wr(IDX_T0_HIGH, 8'hfe);
    wr(IDX_TIMER_CTRL, 8'h40);
    wt(1, 12);
    chk(32'h0, {31'h0, fl[0]});
    // timer 2 reload and compare mode 0
    wr(IDX_CMP_HIGH, 8'hff);
    wr(IDX_CMP_LOW, 8'hf8);
    wr(IDX_RELOAD_HIGH, 8'h12);
    wr(IDX_RELOAD_LOW, 8'h00);
    wr(IDX_T2_HIGH, 8'hff);
    wr(IDX_T2_LOW, 8'he0);
    wr(IDX_T2_CTRL, 8'h11);
    wt(3, 40);
    chk(32'h1, {31'h0, pin});
    wt(2, 20);
    chk(32'h0, {31'h0, pin});
    rd(IDX_T2_HIGH, 8'h12);
    rd(IDX_T2_FLAGS, 8'h11);
    wr(IDX_CMP_INV, 8'h01);
    repeat (2) @(posedge clk);
    chk(32'h1, {31'h0, pin});
    wr(IDX_CMP_INV, 8'h00);
    // compare mode 1 drives the port bit only at match
    wr(IDX_T2_FLAGS, 8'h00);
    wr(IDX_CMP_PORT, 8'h01);
    wr(IDX_T2_CTRL, 8'h15);
    wr(IDX_T2_LOW, 8'he0);
    wr(IDX_T2_HIGH, 8'hff);
    chk(32'h0, {31'h0, pin});
    wt(3, 40);
    chk(32'h1, {31'h0, pin});
    // prescaler halves the rate, input select stops
    wr(IDX_T2_CTRL, 8'h81);
    apb(1'b0, IDX_T2_LOW, 8'h00);
    s = r;
    apb(1'b0, IDX_T2_LOW, 8'h00);
    chk(32'h1, {31'h0, (r[7:0] - s[7:0]) inside {8'h1, 8'h2}});
    wr(IDX_T2_CTRL, 8'h00);
    apb(1'b0, IDX_T2_LOW, 8'h00);
    s = r;
    rd(IDX_T2_LOW, s[7:0]);
    final_report();
  end
endmodule
`default_nettype wire
